// [inc/timer_consts.vh]
// constants for the dual timer/counter: offsets, fields, reset values, timing
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
// byte offsets on the register bus
`define OFS_CONTROL 12'h088
`define OFS_MODE 12'h089
`define OFS_LOW0 12'h08A
`define OFS_LOW1 12'h08B
`define OFS_HIGH0 12'h08C
`define OFS_HIGH1 12'h08D
`define OFS_ACK 12'h090
// control register fields
`define CTL_OVF1 7
`define CTL_RUN1 6
`define CTL_OVF0 5
`define CTL_RUN0 4
// mode register fields, timer 0 in the low nibble, timer 1 in the high nibble
`define MOD_QUAL1 7
`define MOD_SRC1 6
`define MOD_HI1 5
`define MOD_LO1 4
`define MOD_QUAL0 3
`define MOD_SRC0 2
`define MOD_HI0 1
`define MOD_LO0 0
// reset values
`define CONTROL_RESET 8'h00
`define MODE_RESET 8'h00
`define COUNT_RESET 8'h00
// timing: machine cycle length in cpu clocks
`define MACHINE_CLOCKS 6
`define MCYC_CNT_W 3
`endif

// [src/count_pin_sampler.v]
// pin synchroniser and once-per-machine-cycle falling edge detector
module count_pin_sampler
(
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire tick,
  input wire pin,
  output reg fall
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg stable_reg;
  reg prev_reg;
  // three stages; the level counts once the last two agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      stable_reg <= 1'b0;
      prev_reg <= 1'b0;
      fall <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        stable_reg <= s3_reg;
      fall <= 1'b0;
      if (tick)
      begin
        // one sample per machine cycle; high then low is one count
        prev_reg <= stable_reg;
        fall <= prev_reg & ~stable_reg;
      end
    end
  end
endmodule

// [src/dual_timer_counter.v]
// two 16-bit timer/counters with modes 0 to 3 behind an APB slave
// ***************************************************************
// ***************************************************************
`include "timer_consts.vh"
module dual_timer_counter
#(
  parameter MACHINE_CLOCKS = `MACHINE_CLOCKS
)
(
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire count_pin_zero,
  input wire count_pin_one,
  input wire ext_irq_pin_zero,
  input wire ext_irq_pin_one,
  input wire vector_ack_zero,
  input wire vector_ack_one,
  output reg overflow_flag_zero,
  output reg overflow_flag_one
);
  // ***************************************************************
  // machine cycle timing
  // ***************************************************************
  reg [`MCYC_CNT_W-1:0] mcyc_reg;
  reg tick_reg;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcyc_reg <= {`MCYC_CNT_W{1'b0}};
      tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      // one tick every six clocks marks a machine cycle
      tick_reg <= (mcyc_reg == MACHINE_CLOCKS - 1);
      if (mcyc_reg == MACHINE_CLOCKS - 1)
        mcyc_reg <= {`MCYC_CNT_W{1'b0}};
      else
        mcyc_reg <= mcyc_reg + 1'b1;
    end
  end

  // ***************************************************************
  // pin inputs
  // ***************************************************************
  wire [1:0] fall;
  wire [1:0] cpin;
  wire [1:0] gpin;
  // one driver per bit: each channel keeps its gate stages in its own block
  wire [1:0] gate_reg;
  assign cpin = {count_pin_one, count_pin_zero};
  assign gpin = {ext_irq_pin_one, ext_irq_pin_zero};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : chan
      count_pin_sampler u_smp
      (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(tick_reg),
        .pin(cpin[gi]),
        .fall(fall[gi])
      );
      reg [2:0] gs_reg;
      reg gl_reg;
      assign gate_reg[gi] = gl_reg;
      // gate pin: three stages, level taken when last two agree
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          gs_reg <= 3'h0;
          gl_reg <= 1'b0;
        end
        else if (ce)
        begin
          gs_reg <= {gs_reg[1:0], gpin[gi]};
          if (gs_reg[1] == gs_reg[2])
            gl_reg <= gs_reg[2];
        end
      end
    end
  endgenerate

  // ***************************************************************
  // registers
  // ***************************************************************
  reg [7:0] timer_control_reg;
  reg [7:0] timer_mode_reg;
  reg [7:0] low_reg [0:1];
  reg [7:0] high_reg [0:1];
  wire run_bit_zero = timer_control_reg[`CTL_RUN0];
  wire run_bit_one = timer_control_reg[`CTL_RUN1];
  wire [1:0] mode0 = timer_mode_reg[`MOD_HI0:`MOD_LO0];
  wire [1:0] mode1 = timer_mode_reg[`MOD_HI1:`MOD_LO1];
  wire setup_wr = psel & ~penable & pwrite;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;

  // qualified count enables per timer
  wire en0 = run_bit_zero & (~timer_mode_reg[`MOD_QUAL0] | gate_reg[0]);
  // timer 1 halts in its own mode 3
  wire en1 = run_bit_one & (~timer_mode_reg[`MOD_QUAL1] | gate_reg[1])
    & (mode1 != 2'd3);
  // source select: machine cycle tick or pin falling edge
  wire inc0 = en0 & (timer_mode_reg[`MOD_SRC0] ? fall[0] : tick_reg);
  wire inc1 = en1 & (timer_mode_reg[`MOD_SRC1] ? fall[1] : tick_reg);
  // timer 0 mode 3 high byte: cycles only, under timer 1 run bit
  wire inc_h0 = (mode0 == 2'd3) & run_bit_one & tick_reg;

  // ***************************************************************
  // counting
  // ***************************************************************
  reg [7:0] lo_next [0:1];
  reg [7:0] hi_next [0:1];
  reg [1:0] ovf_next;
  reg ovf_h0;
  reg [1:0] incv;
  reg [1:0] mv [0:1];
  integer i;
  always @*
  begin
    incv = {inc1, inc0};
    mv[0] = mode0;
    mv[1] = mode1;
    ovf_next = 2'b00;
    ovf_h0 = 1'b0;
    for (i = 0; i < 2; i = i + 1)
    begin
      lo_next[i] = low_reg[i];
      hi_next[i] = high_reg[i];
      if (incv[i])
      begin
        case (mv[i])
          2'd0:
          begin
            // five-bit prescaler; upper low bits left alone
            lo_next[i] = {low_reg[i][7:5], low_reg[i][4:0] + 5'h01};
            if (low_reg[i][4:0] == 5'h1F)
            begin
              hi_next[i] = high_reg[i] + 8'h01;
              ovf_next[i] = (high_reg[i] == 8'hFF);
            end
          end
          2'd1:
          begin
            {hi_next[i], lo_next[i]} = {high_reg[i], low_reg[i]} + 16'h0001;
            ovf_next[i] = ({high_reg[i], low_reg[i]} == 16'hFFFF);
          end
          2'd2:
          begin
            if (low_reg[i] == 8'hFF)
            begin
              lo_next[i] = high_reg[i];
              ovf_next[i] = 1'b1;
            end
            else
              lo_next[i] = low_reg[i] + 8'h01;
          end
          default:
          begin
            // only timer 0 reaches here: low byte as plain 8 bits
            lo_next[i] = low_reg[i] + 8'h01;
            ovf_next[i] = (low_reg[i] == 8'hFF);
          end
        endcase
      end
    end
    if (inc_h0)
    begin
      hi_next[0] = high_reg[0] + 8'h01;
      ovf_h0 = (high_reg[0] == 8'hFF);
    end
  end

  // flag sources: timer 1 flag is owned by timer 0 high byte in mode 3
  wire set_f0 = ovf_next[0];
  wire set_f1 = (mode0 == 2'd3) ? ovf_h0 : ovf_next[1];

  // ***************************************************************
  // register update and APB writes
  // ***************************************************************
  // software write wins over counting for the byte written
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_reg <= `CONTROL_RESET;
      timer_mode_reg <= `MODE_RESET;
      low_reg[0] <= `COUNT_RESET;
      low_reg[1] <= `COUNT_RESET;
      high_reg[0] <= `COUNT_RESET;
      high_reg[1] <= `COUNT_RESET;
    end
    else if (ce)
    begin
      low_reg[0] <= lo_next[0];
      low_reg[1] <= lo_next[1];
      high_reg[0] <= hi_next[0];
      high_reg[1] <= hi_next[1];
      // run bits only stored; count left as is when started
      if (wr && paddr == `OFS_CONTROL)
      begin
        timer_control_reg[`CTL_RUN1] <= pwdata[`CTL_RUN1];
        timer_control_reg[`CTL_RUN0] <= pwdata[`CTL_RUN0];
      end
      // flags: a set in the same cycle as a clear is kept
      if (set_f1)
        timer_control_reg[`CTL_OVF1] <= 1'b1;
      else if (vector_ack_one || (wr && paddr == `OFS_CONTROL && !pwdata[`CTL_OVF1]))
        timer_control_reg[`CTL_OVF1] <= 1'b0;
      if (set_f0)
        timer_control_reg[`CTL_OVF0] <= 1'b1;
      else if (vector_ack_zero || (wr && paddr == `OFS_CONTROL && !pwdata[`CTL_OVF0]))
        timer_control_reg[`CTL_OVF0] <= 1'b0;
      if (wr && paddr == `OFS_MODE)
        timer_mode_reg <= pwdata[7:0];
      if (wr && paddr == `OFS_LOW0)
        low_reg[0] <= pwdata[7:0];
      if (wr && paddr == `OFS_LOW1)
        low_reg[1] <= pwdata[7:0];
      if (wr && paddr == `OFS_HIGH0)
        high_reg[0] <= pwdata[7:0];
      if (wr && paddr == `OFS_HIGH1)
        high_reg[1] <= pwdata[7:0];
    end
  end

  // ***************************************************************
  // APB answer and flag outputs
  // ***************************************************************
  reg [31:0] rd_mux;
  reg hit;
  always @*
  begin
    hit = 1'b1;
    case (paddr)
      `OFS_CONTROL: rd_mux = {24'h000000, timer_control_reg};
      `OFS_MODE: rd_mux = {24'h000000, timer_mode_reg};
      `OFS_LOW0: rd_mux = {24'h000000, low_reg[0]};
      `OFS_LOW1: rd_mux = {24'h000000, low_reg[1]};
      `OFS_HIGH0: rd_mux = {24'h000000, high_reg[0]};
      `OFS_HIGH1: rd_mux = {24'h000000, high_reg[1]};
      default:
      begin
        rd_mux = 32'h00000000;
        hit = 1'b0;
      end
    endcase
  end

  // no wait state: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      overflow_flag_zero <= 1'b0;
      overflow_flag_one <= 1'b0;
    end
    else if (ce)
    begin
      overflow_flag_zero <= timer_control_reg[`CTL_OVF0];
      overflow_flag_one <= timer_control_reg[`CTL_OVF1];
      if (psel && !penable)
      begin
        pready <= 1'b1;
        pslverr <= ~hit;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
  // setup_wr kept for symmetry of decode is unused otherwise
  wire unused_setup = setup_wr;
endmodule

// [test/dual_timer_counter_chk.sv]
// port checker for the dual timer/counter
`include "timer_consts.vh"
module dual_timer_counter_chk
#(
  parameter MACHINE_CLOCKS = 6
)
(
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic count_pin_zero,
  input logic count_pin_one,
  input logic ext_irq_pin_zero,
  input logic ext_irq_pin_one,
  input logic vector_ack_zero,
  input logic vector_ack_one,
  input logic overflow_flag_zero,
  input logic overflow_flag_one
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr >= `OFS_CONTROL && paddr <= `OFS_HIGH1;
  wire done = psel && penable && pready;
  // ****************
  // bus and flags
  // ****************
  ready_resp_a: assert property (psel && !penable && ce ##1 ce |-> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("answer not a single pulse");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  unmapped_err_a: assert property (done && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (done && mapped |-> !pslverr)
    else $error("mapped access refused");
  err_rdata_a: assert property (done && !pwrite && pslverr |-> prdata == 32'h00000000)
    else $error("refused read not zero");
  ctl_unused_a: assert property (done && !pwrite && paddr == `OFS_CONTROL
    |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h000000)
    else $error("control unused bits not zero");
  ack_clear0_a: assert property (vector_ack_zero |-> ##2 !overflow_flag_zero)
    else $error("flag zero not cleared by ack");
  ack_clear1_a: assert property (vector_ack_one |-> ##2 !overflow_flag_one)
    else $error("flag one not cleared by ack");
  flag_hold_a: assert property (overflow_flag_zero && !$past(vector_ack_zero)
    && !$past(psel) |=> overflow_flag_zero)
    else $error("flag zero lost without a clear");
  ce_freeze_a: assert property (!ce |=> $stable(prdata) && $stable(pready)
    && $stable(overflow_flag_zero) && $stable(overflow_flag_one))
    else $error("state moved while clock enable low");
  cover property (done && pslverr);
  cover property ($rose(overflow_flag_zero));
  cover property ($rose(overflow_flag_one));
endmodule
bind dual_timer_counter dual_timer_counter_chk #(.MACHINE_CLOCKS(MACHINE_CLOCKS)) chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
  .ext_irq_pin_zero(ext_irq_pin_zero), .ext_irq_pin_one(ext_irq_pin_one),
  .vector_ack_zero(vector_ack_zero), .vector_ack_one(vector_ack_one),
  .overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one));

// [test/pin_source.sv]
// far-side model: external count pins and gate pins
module pin_source
(
  input logic pclk,
  output logic [1:0] count_pin,
  output logic [1:0] gate_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // count pins idle high (gate pins low) so the first low count level is a real falling edge
  initial
  begin
    count_pin = 2'b11;
    gate_pin = 2'b00;
  end
  // levels last 6 to 12 clocks: never shorter than one machine cycle
  task pulses(input int t, input int n);
    repeat (n)
    begin
      repeat ($urandom_range(6, 12)) @(posedge pclk);
      count_pin[t] <= 1'b0;
      repeat ($urandom_range(6, 12)) @(posedge pclk);
      count_pin[t] <= 1'b1;
    end
  endtask
  task set_gate(input int t, input logic v);
    @(posedge pclk);
    gate_pin[t] <= v;
  endtask
endmodule

// [test/dual_timer_counter_tb_top.sv]
// self-checking bench for the dual timer/counter
`include "timer_consts.vh"
module dual_timer_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] cpin, gpin, vack, flag;
  logic [15:0] note_q[$];
  logic [15:0] note;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  pin_source src (.pclk(pclk), .count_pin(cpin), .gate_pin(gpin));
  dual_timer_counter #(.MACHINE_CLOCKS(6)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin_zero(cpin[0]), .count_pin_one(cpin[1]),
    .ext_irq_pin_zero(gpin[0]), .ext_irq_pin_one(gpin[1]), .vector_ack_zero(vack[0]),
    .vector_ack_one(vack[1]), .overflow_flag_zero(flag[0]), .overflow_flag_one(flag[1]));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ****************
  // tasks
  // ****************
  task stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // a read notes the accepted range of its low byte; the monitor compares
  task rd(input logic [11:0] a, input logic [7:0] lo, input logic [7:0] hi);
    note_q.push_back({lo, hi});
    apb(1'b0, a, 8'h00);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && note_q.size() > 0)
    begin
      note = note_q.pop_front();
      check((prdata[7:0] >= note[15:8] && prdata[7:0] <= note[7:0]
        && prdata[31:8] === 24'h000000) ? note[15:8] : prdata[7:0], note[15:8]);
    end
  // tick phase is unknown, so overflow may land anywhere in a 12 to 24 clock window
  task wait_flag(input int t);
    int n;
    n = 0;
    while (flag[t] !== 1'b1 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    check(n >= 12 && n <= 24, 1'b1);
  endtask
  task ovf_run(input int t, input logic [1:0] m, input logic [7:0] r);
    logic [7:0] lo, hi, e, h;
    lo = (m == 2'd0) ? {r[7:5], 5'h1D} : 8'hFD;
    hi = (m == 2'd2) ? r % 8'hFE : 8'hFF;
    e = (m == 2'd2) ? hi : {(m == 2'd0) ? lo[7:5] : 3'h0, 5'h00};
    h = (m == 2'd2) ? hi : 8'h00;
    apb(1'b1, `OFS_MODE, t ? {2'b00, m, 4'h0} : {6'h00, m});
    apb(1'b1, t ? `OFS_HIGH1 : `OFS_HIGH0, hi);
    apb(1'b1, t ? `OFS_LOW1 : `OFS_LOW0, lo);
    apb(1'b1, `OFS_CONTROL, t ? 8'h40 : 8'h10);
    wait_flag(t);
    apb(1'b1, `OFS_CONTROL, 8'hA0);
    check(flag[t], 1'b1);
    rd(t ? `OFS_LOW1 : `OFS_LOW0, e, e + 8'h01);
    rd(t ? `OFS_HIGH1 : `OFS_HIGH0, h, h);
    vack[t] <= 1'b1;
    @(posedge pclk);
    vack[t] <= 1'b0;
    repeat (2) @(posedge pclk);
    check(flag[t], 1'b0);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    logic [7:0] r;
    int k;
    r = $urandom(32'h3F2BBFBE);
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    vack = 2'b00;
    ce = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 6; k++)
      rd(`OFS_CONTROL + k, 8'h00, 8'h00);
    rd(12'h0A0, 8'h00, 8'h00);
    apb(1'b1, `OFS_CONTROL, 8'hF5);
    rd(`OFS_CONTROL, 8'h50, 8'h50);
    apb(1'b1, `OFS_CONTROL, 8'h00);
    r = $urandom;
    apb(1'b1, `OFS_HIGH1, r);
    rd(`OFS_HIGH1, r, r);
    for (k = 0; k < 6; k++)
      ovf_run(k / 3, k % 3, $urandom);
    // timer 1 parked in mode 3 while timer 0 splits
    apb(1'b1, `OFS_MODE, 8'h33);
    apb(1'b1, `OFS_LOW1, r);
    apb(1'b1, `OFS_LOW0, r);
    apb(1'b1, `OFS_HIGH0, 8'hFD);
    apb(1'b1, `OFS_CONTROL, 8'h40);
    wait_flag(1);
    rd(`OFS_LOW1, r, r);
    rd(`OFS_LOW0, r, r);
    // freeze while the split high byte still counts; the checker watches outputs
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    for (k = 0; k < 2; k++)
    begin
      r = $urandom_range(3, 9);
      apb(1'b1, `OFS_MODE, k ? 8'h50 : 8'h05);
      apb(1'b1, k ? `OFS_LOW1 : `OFS_LOW0, 8'h00);
      apb(1'b1, `OFS_CONTROL, 8'h50);
      src.pulses(k, r);
      repeat (30) @(posedge pclk);
      rd(k ? `OFS_LOW1 : `OFS_LOW0, r, r);
    end
    apb(1'b1, `OFS_MODE, 8'hD0);
    src.pulses(1, 4);
    repeat (30) @(posedge pclk);
    rd(`OFS_LOW1, r, r);
    src.set_gate(1, 1'b1);
    src.pulses(1, 2);
    repeat (30) @(posedge pclk);
    rd(`OFS_LOW1, r + 8'h02, r + 8'h02);
    stop_test;
  end
endmodule
